// ===== hw/peq_decode.sv
// event-code decoder for one performance counter
`timescale 1ns/1ns
`default_nettype none
module peq_decode
   import peq_pkg::*;
#(
   parameter logic CTR = CTR_ZERO // which counter this decoder serves
) (
   input wire logic [SEL_W-1:0] i_evsel,
   peq_evt_if.dec ev,
   output logic [INC_W-1:0] o_inc
);
   // widen a single-bit occurrence to an increment
   function automatic logic [INC_W-1:0] one_inc(input logic b);
      one_inc = {{(INC_W-1){1'b0}}, b};
   endfunction : one_inc

   // pick the occurrence count for the selected code
   always_comb begin
      case (i_evsel)
         EV_BP_ONE: o_inc = ev.bp_one;
         EV_BP_TWO: o_inc = ev.bp_two;
         EV_BP_THREE: o_inc = ev.bp_three;
         EV_IRQ: o_inc = one_inc(ev.irq);
         EV_DACC: o_inc = ev.dacc;
         EV_DMISS: o_inc = ev.dmiss;
         // counter-specific codes differ between the two counters
         EV_OWN: begin
            o_inc = (CTR == CTR_ZERO) ? one_inc(ev.own_wait)
                                      : one_inc(ev.own_xfer);
         end
         EV_PACKED_OP: begin
            o_inc = (CTR == CTR_ZERO) ? one_inc(ev.pk_op_u)
                                      : one_inc(ev.pk_op_v);
         end
         default: o_inc = '0;
      endcase
   end
endmodule : peq_decode
`default_nettype wire

// ===== hw/peq_top.sv
// event qualification for two counters, event codes 24h to 2bh
`timescale 1ns/1ns
`default_nettype none
module peq_top
   import peq_pkg::*;
(
   input wire logic i_clk, // processor clock
   input wire logic i_rst_n, // synchronous reset, active low
   input wire logic i_ce, // clock enable, freezes all state
   input wire logic [SEL_W-1:0] i_evsel0, // event code of counter 0
   input wire logic [SEL_W-1:0] i_evsel1, // event code of counter 1
   input wire logic i_bp_enabled, // any breakpoint enabled
   input wire logic [2:0] i_bp_code_u, // code match, primary pipe
   input wire logic [2:0] i_bp_code_v, // code match, secondary pipe
   input wire logic [2:0] i_bp_data, // data breakpoint match
   input wire logic i_taken_irq_event, // maskable or nmi taken
   input wire logic [1:0] i_dacc_valid, // data access slots
   input wire logic [1:0] i_dacc_io, // slot targets I/O space
   input wire logic [1:0] i_dacc_walk, // slot is a table walk read
   input wire logic [1:0] i_dacc_miss, // slot missed the data cache
   input wire logic [1:0] i_dacc_cacheable, // miss starts a line fill
   input wire logic [LINE_W-1:0] i_dacc_line0, // line of slot 0
   input wire logic [LINE_W-1:0] i_dacc_line1, // line of slot 1
   input wire logic i_burst_ready_n, // pin, active low
   input wire logic i_private_bus_request, // pin
   input wire logic i_peer_hit_modified_n, // pin, active low
   input wire logic i_hit_modified_n, // pin, active low
   input wire logic i_private_bus_grant, // pin
   input wire logic i_pk_op_u, // packed op retired, primary pipe
   input wire logic i_pk_op_v, // packed op retired, secondary pipe
   output logic [INC_W-1:0] o_inc0, // increment for counter 0
   output logic [INC_W-1:0] o_inc1 // increment for counter 1
);
   // count set bits of a two-bit occurrence vector
   // shared by the breakpoint sums and the data-access sums
   function automatic logic [INC_W-1:0] pop2(input logic [1:0] v);
      pop2 = {1'b0, v[0]} + {1'b0, v[1]};
   endfunction : pop2

   // same line as the fill in progress
   function automatic logic line_hit(input logic [LINE_W-1:0] a,
                                     input logic [LINE_W-1:0] b);
      line_hit = (a == b);
   endfunction : line_hit

   peq_evt_if ev (); // qualified occurrences
   logic [INC_W-1:0] dec0; // decoder output, counter 0
   logic [INC_W-1:0] dec1; // decoder output, counter 1

   // pins move at any phase of the clock, so nothing but the first
   // stage looks at them; pin events pay two clocks of latency for it
   // pin synchroniser, first stage read only by the second
   logic [PIN_W-1:0] pin_s1_r;
   logic [PIN_W-1:0] pin_s2_r;
   logic [PIN_W-1:0] pin_s1_nxt;
   logic [PIN_W-1:0] pin_s2_nxt;
   logic burst_s; // burst ready seen this clock
   logic req_s; // private_bus_request, synchronised
   logic gnt_s; // private_bus_grant, synchronised
   logic req_any; // any ownership request this clock

   // bus ownership state
   logic req_prev_r; // request level one clock ago
   logic req_prev_nxt;
   logic wait_r; // waiting for grant
   logic wait_nxt;

   // line-fill tracker
   peq_fill_type fill_r;
   peq_fill_type fill_nxt;
   logic [LINE_W-1:0] fill_line_r; // line being filled
   logic [LINE_W-1:0] fill_line_nxt;
   logic [2:0] beats_r; // burst-ready strobes seen so far
   logic [2:0] beats_nxt;
   logic supp; // repeat misses are being swallowed

   // access qualification
   logic [1:0] dacc_q; // counted data accesses
   logic [1:0] miss_q; // counted data misses
   logic [1:0] same_line; // slot hits the line under fill

   logic [INC_W-1:0] inc0_nxt;
   logic [INC_W-1:0] inc1_nxt;

   // next values of the pin synchroniser
   always_comb begin
      pin_s1_nxt = {i_private_bus_grant, i_hit_modified_n,
                    i_peer_hit_modified_n, i_private_bus_request,
                    i_burst_ready_n};
      pin_s2_nxt = pin_s1_r;
   end

   // two flops per pin, idle levels under reset
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pin_s1_r <= PIN_RST;
         pin_s2_r <= PIN_RST;
      end else if (i_ce) begin
         pin_s1_r <= pin_s1_nxt;
         pin_s2_r <= pin_s2_nxt;
      end
   end

   // synchronised pin levels, active-low ones turned round
   always_comb begin
      burst_s = ~pin_s2_r[PIN_BURST];
      req_s = pin_s2_r[PIN_REQ];
      gnt_s = pin_s2_r[PIN_GNT];
      req_any = req_s | ~pin_s2_r[PIN_PEER_HIT] | ~pin_s2_r[PIN_HIT];
   end

   // breakpoint, interrupt and packed-op occurrences
   always_comb begin
      // data matches count whether breakpoints are enabled or not
      // disabled breakpoints: secondary-pipe code matches are not checked
      ev.bp_one = pop2({i_bp_code_u[0], i_bp_code_v[0] & i_bp_enabled})
                  + {1'b0, i_bp_data[0]};
      ev.bp_two = pop2({i_bp_code_u[1], i_bp_code_v[1] & i_bp_enabled})
                  + {1'b0, i_bp_data[1]};
      ev.bp_three = pop2({i_bp_code_u[2], i_bp_code_v[2] & i_bp_enabled})
                    + {1'b0, i_bp_data[2]};
      ev.irq = i_taken_irq_event;
      ev.pk_op_u = i_pk_op_u;
      ev.pk_op_v = i_pk_op_v;
   end

   // data access and miss qualification
   always_comb begin
      same_line[0] = line_hit(i_dacc_line0, fill_line_r);
      same_line[1] = line_hit(i_dacc_line1, fill_line_r);
      // a walk read that also misses is kept out of both counts
      // split halves arrive as separate slots, so each counts alone
      dacc_q = i_dacc_valid & ~i_dacc_io & ~i_dacc_walk;
      // hit or miss does not matter for the access count
      miss_q = dacc_q & i_dacc_miss & ~({2{supp}} & same_line);
      ev.dacc = pop2(dacc_q);
      ev.dmiss = pop2(miss_q);
   end

   // only one fill is tracked at a time: a cacheable miss while busy
   // starts nothing, so repeats to that second line count as misses;
   // one line register was traded against a small miss overcount
   // line-fill tracker: swallow repeats after first beat until the last
   always_comb begin
      fill_nxt = fill_r;
      fill_line_nxt = fill_line_r;
      beats_nxt = beats_r;
      supp = (fill_r == FILL_BUSY) && (beats_r != 3'h0);
      case (fill_r)
         FILL_IDLE: begin
            // slot 0 wins if both slots start a fill at once
            if (miss_q[0] && i_dacc_cacheable[0]) begin
               fill_nxt = FILL_BUSY;
               fill_line_nxt = i_dacc_line0;
               beats_nxt = 3'h0;
            end else if (miss_q[1] && i_dacc_cacheable[1]) begin
               fill_nxt = FILL_BUSY;
               fill_line_nxt = i_dacc_line1;
               beats_nxt = 3'h0;
            end
         end
         FILL_BUSY: begin
            if (burst_s) begin
               // fourth strobe closes the fill
               if (beats_r == FILL_LAST) begin
                  fill_nxt = FILL_IDLE;
                  beats_nxt = 3'h0;
               end else begin
                  beats_nxt = beats_r + 3'h1;
               end
            end
         end
         default: begin
            fill_nxt = FILL_IDLE;
            beats_nxt = 3'h0;
         end
      endcase
   end

   // fill tracker registers
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         fill_r <= FILL_IDLE;
         fill_line_r <= '0;
         beats_r <= 3'h0;
      end else if (i_ce) begin
         fill_r <= fill_nxt;
         fill_line_r <= fill_line_nxt;
         beats_r <= beats_nxt;
      end
   end

   // a request pulse shorter than a clock may slip past the
   // synchroniser and go uncounted; pins are expected to hold
   // for several clocks, as ownership requests do
   // bus ownership: wait clocks from earliest request to grant
   always_comb begin
      ev.own_wait = (wait_r | req_any) & ~gnt_s;
      ev.own_xfer = req_s & ~req_prev_r;
      wait_nxt = ev.own_wait;
      req_prev_nxt = req_s;
   end

   // ownership registers
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wait_r <= 1'b0;
         req_prev_r <= 1'b0;
      end else if (i_ce) begin
         wait_r <= wait_nxt;
         req_prev_r <= req_prev_nxt;
      end
   end

   // one decoder per counter since codes 2ah and 2bh differ
   peq_decode #(.CTR(CTR_ZERO)) u_dec0 (
      .i_evsel(i_evsel0),
      .ev(ev.dec),
      .o_inc(dec0)
   );
   peq_decode #(.CTR(CTR_ONE)) u_dec1 (
      .i_evsel(i_evsel1),
      .ev(ev.dec),
      .o_inc(dec1)
   );

   // increments are registered so the counter adder sees clean flops
   // the flop costs one clock of latency, accepted for a short path
   always_comb begin
      inc0_nxt = dec0;
      inc1_nxt = dec1;
   end

   // output registers
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_inc0 <= '0;
         o_inc1 <= '0;
      end else if (i_ce) begin
         o_inc0 <= inc0_nxt;
         o_inc1 <= inc1_nxt;
      end
   end

   // checks
   // checks that look across an edge are gated by the clock enable
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   bp_one_a: assert property (i_ce && i_evsel0 == EV_BP_ONE |=>
      o_inc0 == $past(ev.bp_one)) else $error("bp one count wrong");
   bp_vpipe_a: assert property (!i_bp_enabled && i_bp_code_v[0] &&
      !i_bp_code_u[0] && !i_bp_data[0] |-> ev.bp_one == 2'h0)
      else $error("disabled v-pipe match counted");
   irq_count_a: assert property (i_ce && i_evsel1 == EV_IRQ &&
      i_taken_irq_event |=> o_inc1 == 2'h1)
      else $error("interrupt not counted");
   dacc_pair_a: assert property (i_dacc_valid == 2'b11 &&
      i_dacc_io == 2'b00 && i_dacc_walk == 2'b00 |-> ev.dacc == 2'h2)
      else $error("dual access not counted twice");
   dacc_excl_a: assert property (i_dacc_valid == 2'b01 &&
      (i_dacc_io[0] || i_dacc_walk[0]) |-> ev.dacc == 2'h0 &&
      ev.dmiss == 2'h0) else $error("excluded access counted");
   miss_fill_a: assert property (supp && i_dacc_valid == 2'b01 &&
      same_line[0] |-> ev.dmiss == 2'h0)
      else $error("refill repeat miss counted");
   fill_end_a: assert property (i_ce && fill_r == FILL_BUSY &&
      beats_r == FILL_LAST && burst_s |=> fill_r == FILL_IDLE)
      else $error("fill not closed on fourth beat");
   own_wait_a: assert property (i_ce && wait_r && !gnt_s |->
      ev.own_wait ##1 wait_r) else $error("wait clock dropped");
   own_xfer_a: assert property (i_ce && ev.own_xfer |=>
      !ev.own_xfer) else $error("one request counted twice");
   pk_pipe_a: assert property (i_ce && i_evsel0 == EV_PACKED_OP &&
      i_evsel1 == EV_PACKED_OP |=> o_inc0 == {1'b0, $past(i_pk_op_u)} &&
      o_inc1 == {1'b0, $past(i_pk_op_v)}) else $error("pipe mixup");
   unsup_code_a: assert property (i_ce && (i_evsel0 < EV_BP_ONE ||
      i_evsel0 > EV_PACKED_OP) |=> o_inc0 == 2'h0)
      else $error("unsupported code counted");

   dual_acc_c: cover property (ev.dacc == 2'h2);
   fill_supp_c: cover property (supp && miss_q == 2'b00 &&
      (i_dacc_valid[0] && i_dacc_miss[0] && same_line[0]));
   own_wait_c: cover property (wait_r && gnt_s);
   own_xfer_c: cover property (ev.own_xfer);
endmodule : peq_top
`default_nettype wire

// ===== inc/peq_evt_if.sv
// qualified per-clock event occurrences passed to the counter decoders
`timescale 1ns/1ns
`default_nettype none
interface peq_evt_if;
   import peq_pkg::*;
   logic [INC_W-1:0] bp_one; // matches on debug_addr_reg_one
   logic [INC_W-1:0] bp_two; // matches on debug_addr_reg_two
   logic [INC_W-1:0] bp_three; // matches on debug_addr_reg_three
   logic irq; // taken_irq_event
   logic [INC_W-1:0] dacc; // qualified data accesses
   logic [INC_W-1:0] dmiss; // qualified data misses
   logic own_wait; // one clock of bus ownership latency
   logic own_xfer; // one bus ownership transfer
   logic pk_op_u; // packed op in primary pipe
   logic pk_op_v; // packed op in secondary pipe
   modport src (
      output bp_one, bp_two, bp_three, irq, dacc, dmiss,
      output own_wait, own_xfer, pk_op_u, pk_op_v
   );
   modport dec (
      input bp_one, bp_two, bp_three, irq, dacc, dmiss,
      input own_wait, own_xfer, pk_op_u, pk_op_v
   );
endinterface : peq_evt_if
`default_nettype wire

// ===== inc/peq_pkg.sv
// shared constants for the event qualifier and its per-counter decoders
package peq_pkg;
   // event select field width and supported event codes
   localparam int SEL_W = 6;
   localparam logic [5:0] EV_BP_ONE = 6'h24;
   localparam logic [5:0] EV_BP_TWO = 6'h25;
   localparam logic [5:0] EV_BP_THREE = 6'h26;
   localparam logic [5:0] EV_IRQ = 6'h27;
   localparam logic [5:0] EV_DACC = 6'h28;
   localparam logic [5:0] EV_DMISS = 6'h29;
   localparam logic [5:0] EV_OWN = 6'h2a;
   localparam logic [5:0] EV_PACKED_OP = 6'h2b;
   // width of a per-clock increment (at most three occurrences)
   localparam int INC_W = 2;
   // number of cache-line address bits compared by the miss filter
   localparam int LINE_W = 27;
   // burst-ready strobes in one line fill, and the last beat index
   localparam logic [2:0] FILL_BEATS = 3'h4;
   localparam logic [2:0] FILL_LAST = 3'h3;
   // pin synchroniser bit positions
   localparam int PIN_W = 5;
   localparam int PIN_BURST = 0;
   localparam int PIN_REQ = 1;
   localparam int PIN_PEER_HIT = 2;
   localparam int PIN_HIT = 3;
   localparam int PIN_GNT = 4;
   // idle level of the pins: the three active-low ones sit high
   localparam logic [4:0] PIN_RST = 5'h0d;
   // counter indices
   localparam logic CTR_ZERO = 1'b0;
   localparam logic CTR_ONE = 1'b1;
   // states of the line-fill tracker
   typedef enum logic [0:0] {
      FILL_IDLE = 1'b0,
      FILL_BUSY = 1'b1
   } peq_fill_type;
endpackage : peq_pkg

// ===== testbench/tb_peq_top.sv
// self-checking bench for the two-counter event qualifier
`timescale 1ns/1ns
`default_nettype none
module tb_peq_top;
   import peq_pkg::*;
   // one cycle of same-domain inputs and the increments they should give
   typedef struct packed {
      logic [5:0] s0, s1;
      logic en;
      logic [2:0] bu, bv, bd;
      logic irq;
      logic [1:0] val, io, walk, miss;
      logic mu, mv;
      logic [1:0] e0, e1;
   } peq_row_type;
   localparam int NROW = 12;
   localparam int LIMIT = 1000; // cycle ceiling, run needs about 120
   logic i_clk, i_rst_n, i_ce, i_bp_enabled, i_taken_irq_event;
   logic i_burst_ready_n, i_private_bus_request, i_private_bus_grant;
   logic i_peer_hit_modified_n, i_hit_modified_n, i_pk_op_u, i_pk_op_v;
   logic [SEL_W-1:0] i_evsel0, i_evsel1;
   logic [2:0] i_bp_code_u, i_bp_code_v, i_bp_data;
   logic [1:0] i_dacc_valid, i_dacc_io, i_dacc_walk, i_dacc_miss;
   logic [1:0] i_dacc_cacheable;
   logic [LINE_W-1:0] i_dacc_line0, i_dacc_line1;
   logic [INC_W-1:0] o_inc0, o_inc1;
   logic [7:0] sum0, sum1; // increments gathered over a window
   logic summing; // window open
   int fail_count, samples_checked, cycles;
   peq_row_type rows [NROW];

   peq_top dut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
      .i_evsel0(i_evsel0), .i_evsel1(i_evsel1),
      .i_bp_enabled(i_bp_enabled), .i_bp_code_u(i_bp_code_u),
      .i_bp_code_v(i_bp_code_v), .i_bp_data(i_bp_data),
      .i_taken_irq_event(i_taken_irq_event),
      .i_dacc_valid(i_dacc_valid), .i_dacc_io(i_dacc_io),
      .i_dacc_walk(i_dacc_walk), .i_dacc_miss(i_dacc_miss),
      .i_dacc_cacheable(i_dacc_cacheable),
      .i_dacc_line0(i_dacc_line0), .i_dacc_line1(i_dacc_line1),
      .i_burst_ready_n(i_burst_ready_n),
      .i_private_bus_request(i_private_bus_request),
      .i_peer_hit_modified_n(i_peer_hit_modified_n),
      .i_hit_modified_n(i_hit_modified_n),
      .i_private_bus_grant(i_private_bus_grant),
      .i_pk_op_u(i_pk_op_u), .i_pk_op_v(i_pk_op_v),
      .o_inc0(o_inc0), .o_inc1(o_inc1)
   );

   // free-running 10 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   // gather increments at the falling edge, where outputs are settled
   always @(negedge i_clk) begin
      if (summing) begin
         sum0 = sum0 + {6'h00, o_inc0};
         sum1 = sum1 + {6'h00, o_inc1};
      end
   end

   // hang guard: a run that outlives the ceiling is a mismatch
   always @(posedge i_clk) begin
      cycles = cycles + 1;
      if (cycles == LIMIT) begin
         fail_count = fail_count + 1;
         print_verdict();
      end
   end

   // compare one value, case equality so unknowns never match
   task chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // put one row on the same-domain inputs, cacheable misses kept off
   task drive(input peq_row_type r);
      i_evsel0 <= r.s0;
      i_evsel1 <= r.s1;
      i_bp_enabled <= r.en;
      i_bp_code_u <= r.bu;
      i_bp_code_v <= r.bv;
      i_bp_data <= r.bd;
      i_taken_irq_event <= r.irq;
      i_dacc_valid <= r.val;
      i_dacc_io <= r.io;
      i_dacc_walk <= r.walk;
      i_dacc_miss <= r.miss;
      i_dacc_cacheable <= 2'h0;
      i_pk_op_u <= r.mu;
      i_pk_op_v <= r.mv;
   endtask : drive

   // one access cycle: mask m valid and missing, c marks cacheable
   task acc(input logic [1:0] m, input logic [1:0] c);
      @(posedge i_clk);
      i_dacc_valid <= m;
      i_dacc_miss <= m;
      i_dacc_cacheable <= c;
      @(posedge i_clk);
      i_dacc_valid <= 2'h0;
      i_dacc_miss <= 2'h0;
      i_dacc_cacheable <= 2'h0;
   endtask : acc

   // one fill beat: burst-ready low for a single clock
   task beat;
      @(posedge i_clk);
      i_burst_ready_n <= 1'b0;
      @(posedge i_clk);
      i_burst_ready_n <= 1'b1;
   endtask : beat

   // ownership request from source src, grant after gap clocks
   task own_run(input int src, input int gap);
      @(posedge i_clk);
      i_evsel0 <= EV_OWN;
      i_evsel1 <= EV_OWN;
      sum0 = 8'h00;
      sum1 = 8'h00;
      summing = 1'b1;
      if (src == 0) i_private_bus_request <= 1'b1;
      else if (src == 1) i_peer_hit_modified_n <= 1'b0;
      else i_hit_modified_n <= 1'b0;
      repeat (gap) @(posedge i_clk);
      i_private_bus_grant <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_private_bus_request <= 1'b0;
      i_peer_hit_modified_n <= 1'b1;
      i_hit_modified_n <= 1'b1;
      i_private_bus_grant <= 1'b0;
      repeat (6) @(posedge i_clk);
      summing = 1'b0;
      chk(sum0, 8'(gap));
      chk(sum1, (src == 0) ? 8'h01 : 8'h00);
   endtask : own_run

   // final counts and verdict, the only way the run ends
   task print_verdict;
      $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict

   // main sequence
   initial begin
      rows[0] = '{EV_BP_ONE, EV_BP_TWO, 1'h1, 3'h1, 3'h2, 3'h3, 1'h0,
         2'h0, 2'h0, 2'h0, 2'h0, 1'h0, 1'h0, 2'h2, 2'h2};
      rows[1] = '{EV_BP_THREE, EV_BP_ONE, 1'h0, 3'h4, 3'h7, 3'h4, 1'h0,
         2'h0, 2'h0, 2'h0, 2'h0, 1'h0, 1'h0, 2'h2, 2'h0};
      rows[2] = '{EV_BP_THREE, EV_BP_THREE, 1'h1, 3'h4, 3'h4, 3'h4, 1'h0,
         2'h0, 2'h0, 2'h0, 2'h0, 1'h0, 1'h0, 2'h3, 2'h3};
      rows[3] = '{EV_IRQ, EV_IRQ, 1'h0, 3'h0, 3'h0, 3'h0, 1'h1,
         2'h0, 2'h0, 2'h0, 2'h0, 1'h0, 1'h0, 2'h1, 2'h1};
      rows[4] = '{EV_DACC, EV_DMISS, 1'h0, 3'h0, 3'h0, 3'h0, 1'h0,
         2'h3, 2'h0, 2'h0, 2'h1, 1'h0, 1'h0, 2'h2, 2'h1};
      rows[5] = '{EV_DACC, EV_DMISS, 1'h0, 3'h0, 3'h0, 3'h0, 1'h0,
         2'h3, 2'h1, 2'h2, 2'h3, 1'h0, 1'h0, 2'h0, 2'h0};
      rows[6] = '{EV_DACC, EV_DMISS, 1'h0, 3'h0, 3'h0, 3'h0, 1'h0,
         2'h3, 2'h2, 2'h0, 2'h3, 1'h0, 1'h0, 2'h1, 2'h1};
      rows[7] = '{EV_PACKED_OP, EV_PACKED_OP, 1'h0, 3'h0, 3'h0, 3'h0, 1'h0,
         2'h0, 2'h0, 2'h0, 2'h0, 1'h1, 1'h0, 2'h1, 2'h0};
      rows[8] = '{EV_PACKED_OP, EV_PACKED_OP, 1'h0, 3'h0, 3'h0, 3'h0, 1'h0,
         2'h0, 2'h0, 2'h0, 2'h0, 1'h0, 1'h1, 2'h0, 2'h1};
      rows[9] = '{6'h23, 6'h2c, 1'h1, 3'h7, 3'h7, 3'h7, 1'h1,
         2'h3, 2'h0, 2'h0, 2'h3, 1'h1, 1'h1, 2'h0, 2'h0};
      rows[10] = '{6'h3f, EV_OWN, 1'h1, 3'h7, 3'h7, 3'h7, 1'h1,
         2'h3, 2'h0, 2'h0, 2'h3, 1'h1, 1'h1, 2'h0, 2'h0};
      rows[11] = '{EV_DACC, EV_DMISS, 1'h0, 3'h0, 3'h0, 3'h0, 1'h0,
         2'h1, 2'h0, 2'h1, 2'h1, 1'h0, 1'h0, 2'h0, 2'h0};
      fail_count = 0;
      samples_checked = 0;
      cycles = 0;
      summing = 1'b0;
      sum0 = 8'h00;
      sum1 = 8'h00;
      // time-zero values; irq held on so reset must mask it
      i_rst_n = 1'b0;
      i_ce = 1'b1;
      drive(rows[3]);
      i_burst_ready_n = 1'b1;
      i_private_bus_request = 1'b0;
      i_peer_hit_modified_n = 1'b1;
      i_hit_modified_n = 1'b1;
      i_private_bus_grant = 1'b0;
      i_dacc_line0 = 27'h0001234;
      i_dacc_line1 = 27'h0005678;
      repeat (11) @(posedge i_clk);
      @(negedge i_clk);
      chk({6'h00, o_inc0}, 8'h00);
      chk({6'h00, o_inc1}, 8'h00);
      // inputs go idle a clock before release, so nothing is pending
      @(posedge i_clk);
      drive('0);
      @(posedge i_clk);
      i_rst_n <= 1'b1;
      // ordinary cases, one row at a time
      for (int k = 0; k < NROW; k++) begin
         @(posedge i_clk);
         drive(rows[k]);
         @(posedge i_clk);
         drive('0);
         @(negedge i_clk);
         chk({6'h00, o_inc0}, {6'h00, rows[k].e0});
         chk({6'h00, o_inc1}, {6'h00, rows[k].e1});
      end
      // clock enable low freezes the registered increment
      @(posedge i_clk);
      i_evsel0 <= EV_IRQ;
      i_taken_irq_event <= 1'b1;
      @(posedge i_clk);
      i_taken_irq_event <= 1'b0;
      i_ce <= 1'b0;
      @(negedge i_clk);
      chk({6'h00, o_inc0}, 8'h01);
      @(negedge i_clk);
      chk({6'h00, o_inc0}, 8'h01);
      @(posedge i_clk);
      i_ce <= 1'b1;
      repeat (2) @(posedge i_clk);
      // fill: repeats to the filled line are dropped between beats
      i_evsel0 <= EV_DMISS;
      i_evsel1 <= EV_DACC;
      sum0 = 8'h00;
      sum1 = 8'h00;
      summing = 1'b1;
      acc(2'h1, 2'h1);
      beat();
      repeat (4) @(posedge i_clk);
      i_dacc_line1 <= 27'h0005678;
      acc(2'h3, 2'h1);
      acc(2'h1, 2'h0);
      beat();
      beat();
      beat();
      repeat (8) @(posedge i_clk);
      acc(2'h1, 2'h0);
      repeat (6) @(posedge i_clk);
      summing = 1'b0;
      chk(sum0, 8'h03);
      chk(sum1, 8'h05);
      // ownership from each of the three request sources
      for (int s = 0; s < 3; s++) begin
         own_run(s, 5);
      end
      print_verdict();
   end
endmodule : tb_peq_top
`default_nettype wire
